// File: rtl/rtc_core.sv
/*
 * BCD timekeeping core: calendar counters, register file, read freeze,
 * oscillator halt and loss detection, trim, test and shared pin drivers.
 * Assumes a serial slave engine on sys_clk that presents one-cycle read
 * and write strobes with a byte address, and a one-cycle stop pulse.
 */
`timescale 1ns/100ps
module rtc_core #(
   parameter int OSC_LOSS_CYCLES = rtc_pkg::OSC_LOSS_CYCLES
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic osc_in,
   input wire logic [2:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic bus_stop,
   output logic [7:0] reg_rdata,
   output logic osc_enable,
   output logic freq_test_pin_out,
   output logic freq_test_pin_oe,
   output logic shared_irq_level_pin_out,
   output logic shared_irq_level_pin_oe,
   output logic osc_fail_irq_pin
);

   // ****************************************
   // Declarations
   // ****************************************
   rtc_pkg::rtc_time_t sys_time;
   rtc_pkg::rtc_time_t next_time;
   rtc_pkg::rtc_time_t user_time;
   rtc_pkg::rtc_trim_t trim;
   logic osc_halt_bit;
   logic osc_fail_irq_enable;
   logic osc_s1;
   logic osc_s2;
   logic osc_s3;
   logic osc_tick;
   logic [12:0] loss_cnt;
   logic osc_lost;
   logic osc_stopped;
   logic freeze;
   logic clock_wr;
   logic sec_pulse;
   logic sq512;
   logic minute_pulse;
   logic leap;
   logic [8:0] inc_sec;
   logic [8:0] inc_min;
   logic [8:0] inc_hour;
   logic [8:0] inc_day;
   logic [8:0] inc_date;
   logic [8:0] inc_month;
   logic [8:0] inc_year;
   logic [7:0] next_rdata;

   assign clock_wr = reg_wr && reg_addr != rtc_pkg::ADDR_TRIM;
   assign osc_tick = osc_s2 && !osc_s3 && !osc_halt_bit;
   assign osc_stopped = osc_halt_bit || osc_lost;

   // ****************************************
   // Oscillator pin synchroniser
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
      end else begin
         osc_s1 <= osc_in;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
      end
   end

   // ****************************************
   // Oscillator loss detection
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         loss_cnt <= 13'h0000;
         osc_lost <= 1'b0;
      end else if (osc_s2 != osc_s3) begin
         loss_cnt <= 13'h0000;
         osc_lost <= 1'b0;
      end else if (loss_cnt == 13'(OSC_LOSS_CYCLES - 1)) begin
         osc_lost <= 1'b1;
      end else begin
         loss_cnt <= 13'(loss_cnt + 13'h0001);
      end
   end

   // ****************************************
   // Divider chain with trim
   // ****************************************
   rtc_osc_div u_div (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .osc_tick(osc_tick),
      .div_clear(clock_wr),
      .minute_pulse(minute_pulse),
      .trim_mag(trim.trim_mag),
      .trim_pos(trim.trim_pos),
      .sec_pulse(sec_pulse),
      .sq512(sq512)
   );

   // ****************************************
   // Calendar carry chain
   // ****************************************
   always_comb begin
      leap = rtc_pkg::rtc_leap(sys_time.year, sys_time.cent);
      inc_sec = rtc_pkg::rtc_bcd_inc(sys_time.sec, 8'h00, 8'h59);
      inc_min = rtc_pkg::rtc_bcd_inc(sys_time.min, 8'h00, 8'h59);
      inc_hour = rtc_pkg::rtc_bcd_inc(sys_time.hour, 8'h00, 8'h23);
      inc_day = rtc_pkg::rtc_bcd_inc(sys_time.day, 8'h01, 8'h07);
      inc_date = rtc_pkg::rtc_bcd_inc(sys_time.date, 8'h01,
         rtc_pkg::rtc_month_len(sys_time.month, leap));
      inc_month = rtc_pkg::rtc_bcd_inc(sys_time.month, 8'h01, 8'h12);
      inc_year = rtc_pkg::rtc_bcd_inc(sys_time.year, 8'h00, 8'h99);
      next_time = sys_time;
      minute_pulse = 1'b0;
      if (sec_pulse) begin
         next_time.sec = inc_sec[7:0];
         if (inc_sec[8]) begin
            minute_pulse = 1'b1;
            next_time.min = inc_min[7:0];
            if (inc_min[8]) begin
               next_time.hour = inc_hour[7:0];
               if (inc_hour[8]) begin
                  next_time.day = inc_day[7:0];
                  next_time.date = inc_date[7:0];
                  if (inc_date[8]) begin
                     next_time.month = inc_month[7:0];
                     if (inc_month[8]) begin
                        next_time.year = inc_year[7:0];
                        if (inc_year[8]) begin
                           next_time.cent = 2'(sys_time.cent + 2'h1);
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // ****************************************
   // System time and write loading
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sys_time <= '{cent: 2'h0, year: rtc_pkg::SEC_RESET,
                       month: rtc_pkg::ONE_RESET, date: rtc_pkg::ONE_RESET,
                       day: rtc_pkg::ONE_RESET, hour: rtc_pkg::SEC_RESET,
                       min: rtc_pkg::SEC_RESET, sec: rtc_pkg::SEC_RESET};
      end else if (clock_wr) begin
         sys_time <= sys_time;
         case (reg_addr)
            rtc_pkg::ADDR_SEC: sys_time.sec <= {1'b0, reg_wdata[6:0]};
            rtc_pkg::ADDR_MIN: sys_time.min <= {1'b0, reg_wdata[6:0]};
            rtc_pkg::ADDR_HOUR: sys_time.hour <= {2'h0, reg_wdata[5:0]};
            rtc_pkg::ADDR_DAY: sys_time.day <= {5'h00, reg_wdata[2:0]};
            rtc_pkg::ADDR_DATE: sys_time.date <= {2'h0, reg_wdata[5:0]};
            rtc_pkg::ADDR_MONTH: begin
               sys_time.month <= {3'h0, reg_wdata[4:0]};
               sys_time.cent <= reg_wdata[7:6];
            end
            rtc_pkg::ADDR_YEAR: sys_time.year <= reg_wdata;
            default: sys_time <= sys_time;
         endcase
      end else begin
         sys_time <= next_time;
      end
   end

   // ****************************************
   // Control bits
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         osc_halt_bit <= 1'b0;
         osc_fail_irq_enable <= 1'b0;
         trim <= rtc_pkg::TRIM_RESET;
      end else if (reg_wr) begin
         if (reg_addr == rtc_pkg::ADDR_SEC) begin
            osc_halt_bit <= reg_wdata[rtc_pkg::HALT_BIT];
         end
         if (reg_addr == rtc_pkg::ADDR_MIN) begin
            osc_fail_irq_enable <= reg_wdata[rtc_pkg::OSC_FAIL_IRQ_ENABLE_BIT];
         end
         if (reg_addr == rtc_pkg::ADDR_TRIM) begin
            trim.out_level <= reg_wdata[rtc_pkg::OUT_BIT];
            trim.ft_en <= reg_wdata[rtc_pkg::FT_BIT];
            trim.trim_pos <= reg_wdata[rtc_pkg::SIGN_BIT];
            trim.trim_mag <= reg_wdata[4:0];
         end
      end
   end

   // ****************************************
   // Read freeze of the user copy
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         freeze <= 1'b0;
      end else if (bus_stop) begin
         freeze <= 1'b0;
      end else if (reg_rd) begin
         freeze <= reg_addr != rtc_pkg::ADDR_TRIM;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         user_time <= '0;
      end else if (!freeze) begin
         user_time <= sys_time;
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   always_comb begin
      case (reg_addr)
         rtc_pkg::ADDR_SEC: next_rdata = {osc_halt_bit, user_time.sec[6:0]};
         rtc_pkg::ADDR_MIN: begin
            next_rdata = {osc_fail_irq_enable, user_time.min[6:0]};
         end
         rtc_pkg::ADDR_HOUR: next_rdata = {2'h0, user_time.hour[5:0]};
         rtc_pkg::ADDR_DAY: next_rdata = {5'h00, user_time.day[2:0]};
         rtc_pkg::ADDR_DATE: next_rdata = {2'h0, user_time.date[5:0]};
         rtc_pkg::ADDR_MONTH: begin
            next_rdata = {user_time.cent, 1'b0, user_time.month[4:0]};
         end
         rtc_pkg::ADDR_YEAR: next_rdata = user_time.year;
         default: next_rdata = trim;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // ****************************************
   // Pins
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         osc_enable <= 1'b1;
         freq_test_pin_out <= 1'b0;
         freq_test_pin_oe <= 1'b0;
         shared_irq_level_pin_out <= 1'b0;
         shared_irq_level_pin_oe <= 1'b0;
         osc_fail_irq_pin <= 1'b0;
      end else begin
         osc_enable <= !osc_halt_bit;
         freq_test_pin_out <= 1'b0;
         freq_test_pin_oe <= !osc_halt_bit && trim.out_level &&
                             trim.ft_en && !sq512;
         shared_irq_level_pin_out <= 1'b0;
         osc_fail_irq_pin <= osc_fail_irq_enable && osc_stopped;
         if (osc_fail_irq_enable) begin
            shared_irq_level_pin_oe <= osc_stopped;
         end else begin
            shared_irq_level_pin_oe <= !trim.out_level;
         end
      end
   end

endmodule

// File: rtl/rtc_pkg.sv
/*
 * Shared constants, types and calendar helpers of the timekeeping core.
 * Assumes a 50 MHz system clock and a 32.768 kHz oscillator pin.
 */
package rtc_pkg;

   // ****************************************
   // Register offsets and field positions
   // ****************************************
   localparam logic [2:0] ADDR_SEC = 3'h0;
   localparam logic [2:0] ADDR_MIN = 3'h1;
   localparam logic [2:0] ADDR_HOUR = 3'h2;
   localparam logic [2:0] ADDR_DAY = 3'h3;
   localparam logic [2:0] ADDR_DATE = 3'h4;
   localparam logic [2:0] ADDR_MONTH = 3'h5;
   localparam logic [2:0] ADDR_YEAR = 3'h6;
   localparam logic [2:0] ADDR_TRIM = 3'h7;
   localparam int HALT_BIT = 7;
   localparam int OSC_FAIL_IRQ_ENABLE_BIT = 7;
   localparam int OUT_BIT = 7;
   localparam int FT_BIT = 6;
   localparam int SIGN_BIT = 5;

   // ****************************************
   // Values after reset
   // ****************************************
   localparam logic [7:0] TRIM_RESET = 8'h80;
   localparam logic [7:0] SEC_RESET = 8'h00;
   localparam logic [7:0] ONE_RESET = 8'h01;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 50000000;
   localparam int OSC_HZ = 32768;
   localparam int FT_HZ = 512;
   localparam int FT_HALF_TICKS = OSC_HZ / (2 * FT_HZ);
   localparam int OSC_LOSS_NS = 122000;
   localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
   localparam int OSC_LOSS_CYCLES = OSC_LOSS_NS / CLK_PERIOD_NS;
   localparam logic [7:0] SPLIT_POINT = 8'h7f;
   localparam logic [7:0] STAGE_LAST = 8'hff;
   localparam logic [6:0] SEC_LAST = 7'h7f;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic [1:0] cent;
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
   } rtc_time_t;

   typedef struct packed {
      logic out_level;
      logic ft_en;
      logic trim_pos;
      logic [4:0] trim_mag;
   } rtc_trim_t;

   // ****************************************
   // BCD helpers
   // ****************************************
   function automatic logic [8:0] rtc_bcd_inc(input logic [7:0] v,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
      logic [8:0] r;
      r = {1'b0, v};
      if (v >= hi) begin
         r = {1'b1, lo};
      end else if (v[3:0] == 4'h9) begin
         r = {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
      end else begin
         r = {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
      end
      return r;
   endfunction

   function automatic logic rtc_leap(input logic [7:0] year,
                                     input logic [1:0] cent);
      logic div4;
      div4 = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                     : (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                        year[3:0] == 4'h8);
      if (year == 8'h00) begin
         return cent == 2'h0;
      end
      return div4;
   endfunction

   function automatic logic [7:0] rtc_month_len(input logic [7:0] month,
                                                input logic leap);
      logic [7:0] r;
      case (month)
         8'h02: r = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
         default: r = 8'h31;
      endcase
      return r;
   endfunction

endpackage

// File: rtl/rtc_osc_div.sv
/*
 * Oscillator divider chain with periodic trim at the divide-by-256 stage
 * and an untrimmed 512 Hz square wave.
 * Assumes osc_tick is a one-cycle pulse per rising oscillator edge, already
 * synchronised to sys_clk.
 */
`timescale 1ns/100ps
module rtc_osc_div (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic osc_tick,
   input wire logic div_clear,
   input wire logic minute_pulse,
   input wire logic [4:0] trim_mag,
   input wire logic trim_pos,
   output logic sec_pulse,
   output logic sq512
);

   // ****************************************
   // State
   // ****************************************
   logic [7:0] low_cnt;
   logic [6:0] high_cnt;
   logic [5:0] cal_min;
   logic adj_pending;
   logic [4:0] ft_cnt;
   logic split_now;
   logic stage_now;
   logic blank_now;

   assign split_now = osc_tick && adj_pending && trim_pos &&
                      low_cnt == rtc_pkg::SPLIT_POINT;
   assign stage_now = osc_tick && low_cnt == rtc_pkg::STAGE_LAST;
   assign blank_now = stage_now && adj_pending && !trim_pos;

   // ****************************************
   // Divide by 256 then by 128
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         low_cnt <= 8'h00;
         high_cnt <= 7'h00;
         sec_pulse <= 1'b0;
      end else begin
         sec_pulse <= 1'b0;
         if (div_clear) begin
            low_cnt <= 8'h00;
            high_cnt <= 7'h00;
         end else if (split_now || (stage_now && !blank_now)) begin
            low_cnt <= 8'h00;
            high_cnt <= 7'(high_cnt + 7'h01);
            sec_pulse <= high_cnt == rtc_pkg::SEC_LAST;
         end else if (osc_tick) begin
            low_cnt <= 8'(low_cnt + 8'h01);
         end
      end
   end

   // ****************************************
   // 64-minute trim cycle
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cal_min <= 6'h00;
         adj_pending <= 1'b0;
      end else begin
         if (minute_pulse) begin
            cal_min <= 6'(cal_min + 6'h01);
            adj_pending <= {1'b0, cal_min} < {trim_mag, 1'b0};
         end else if (split_now || blank_now) begin
            adj_pending <= 1'b0;
         end
      end
   end

   // ****************************************
   // 512 Hz test wave, independent of trim
   // ****************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ft_cnt <= 5'h00;
         sq512 <= 1'b0;
      end else if (osc_tick) begin
         if (ft_cnt == 5'(rtc_pkg::FT_HALF_TICKS - 1)) begin
            ft_cnt <= 5'h00;
            sq512 <= !sq512;
         end else begin
            ft_cnt <= 5'(ft_cnt + 5'h01);
         end
      end
   end

endmodule

// File: testbench/rtc_core_properties.sv
/*
 * Port checker of the timekeeping core, bound onto rtc_core.
 * Assumes an oscillator of two sys_clk cycles per period.
 */
`timescale 1ns/100ps
module rtc_core_chk #(
   parameter int LOSS = 200,
   parameter int FT_HALF = 64
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic osc_in,
   input wire logic [2:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic bus_stop,
   input wire logic [7:0] reg_rdata,
   input wire logic osc_enable,
   input wire logic freq_test_pin_out,
   input wire logic freq_test_pin_oe,
   input wire logic shared_irq_level_pin_out,
   input wire logic shared_irq_level_pin_oe,
   input wire logic osc_fail_irq_pin
);
   // ****************************************
   // Shadow of control bits and pin timing
   // ****************************************
   logic osc_fail_irq_enable_q, halt_q, lvl_q, ft_q, ft_oe_q, ft_arm, osc_q;
   logic [15:0] ft_cnt, quiet_cnt;
   wire ft_ok = lvl_q && ft_q && !halt_q;
   wire ft_chg = freq_test_pin_oe != ft_oe_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         osc_fail_irq_enable_q <= 1'b0;
         halt_q <= 1'b0;
         lvl_q <= 1'b1;
         ft_q <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == 3'h0) halt_q <= reg_wdata[7];
         if (reg_addr == 3'h1) osc_fail_irq_enable_q <= reg_wdata[7];
         if (reg_addr == 3'h7) lvl_q <= reg_wdata[7];
         if (reg_addr == 3'h7) ft_q <= reg_wdata[6];
      end
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ft_oe_q <= 1'b0;
         ft_cnt <= 16'h0000;
         ft_arm <= 1'b0;
      end else begin
         ft_oe_q <= freq_test_pin_oe;
         ft_cnt <= ft_chg ? 16'h0000 : ft_cnt + 16'h0001;
         ft_arm <= ft_ok && (ft_arm || ft_chg);
      end
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         osc_q <= 1'b0;
         quiet_cnt <= 16'h0000;
      end else begin
         osc_q <= osc_in;
         if (osc_in != osc_q) quiet_cnt <= 16'h0000;
         else if (quiet_cnt != 16'hffff) quiet_cnt <= quiet_cnt + 16'h0001;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_halt_ctrl: assert property (reg_wr && reg_addr == 3'h0 |->
      ##2 osc_enable == !halt_q) else $error("oscillator enable wrong");
   a_halt_irq: assert property (reg_wr && reg_addr == 3'h0 &&
      reg_wdata[7] && osc_fail_irq_enable_q |-> ##[1:3] osc_fail_irq_pin)
      else $error("no interrupt on halt");
   a_irq_off: assert property (reg_wr && reg_addr == 3'h1 &&
      !reg_wdata[7] |-> ##[1:3] !osc_fail_irq_pin)
      else $error("interrupt stays after disable");
   a_irq_cause: assert property (osc_fail_irq_pin |-> osc_fail_irq_enable_q ||
      $past(osc_fail_irq_enable_q) || $past(osc_fail_irq_enable_q, 2)) else $error("interrupt not enabled");
   a_shared_level: assert property (!osc_fail_irq_enable_q && !$past(osc_fail_irq_enable_q) &&
      !$past(osc_fail_irq_enable_q, 2) && $past(lvl_q) == lvl_q && $past(lvl_q, 2) == lvl_q
      |-> shared_irq_level_pin_oe == !lvl_q) else $error("level pin wrong");
   a_od_data: assert property (!freq_test_pin_out &&
      !shared_irq_level_pin_out) else $error("open drain data not low");
   a_ft_quiet: assert property (!ft_ok && !$past(ft_ok) &&
      !$past(ft_ok, 2) |-> !ft_chg) else $error("test pin toggles disabled");
   a_ft_period: assert property (ft_chg && ft_arm |->
      ft_cnt == 16'(FT_HALF - 1)) else $error("test pin period wrong");
   a_osc_loss: assert property (osc_fail_irq_enable_q && quiet_cnt == 16'(LOSS + 8) |->
      osc_fail_irq_pin) else $error("no interrupt on oscillator loss");
endmodule

// File: testbench/rtc_xtal_model.sv
/*
 * Crystal model: toggles every 20 ns while allowed to run.
 * Assumes run comes from the core and fail from the bench.
 */
`timescale 1ns/100ps
module rtc_xtal_model (
   input wire logic run,
   input wire logic fail,
   output logic osc_out
);
   // ****************************************
   // Oscillation, stops on halt or failure
   // ****************************************
   initial osc_out = 1'b0;
   always begin
      #20;
      if (run && !fail) osc_out = !osc_out;
   end
endmodule

// File: testbench/testbench.sv
/*
 * Self-checking bench of the timekeeping core through its register port.
 * Assumes the checker and crystal model files are compiled before it.
 */
`timescale 1ns/100ps
module testbench;
   // ****************************************
   // Clock, reset, crystal and core
   // ****************************************
   localparam int LOSS = 200;
   localparam logic [7:0] RST_VAL [8] = '{8'h00, 8'h00, 8'h00, 8'h01,
      8'h01, 8'h01, 8'h00, 8'h80};
   localparam logic [7:0] SET_VAL [7] = '{8'h59, 8'h59, 8'h23, 8'h07,
      8'h31, 8'h12, 8'h99};
   localparam logic [7:0] ROLL_VAL [7] = '{8'h00, 8'h00, 8'h00, 8'h01,
      8'h01, 8'h41, 8'h00};
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic bus_stop = 1'b0;
   logic xtal_fail = 1'b0;
   logic osc_in, osc_enable, ft_out, ft_oe, sh_out, sh_oe, irq;
   logic [7:0] reg_rdata;
   int err_total = 0;
   int n_compared = 0;
   int n;
   always #10 sys_clk = !sys_clk;
   rtc_xtal_model XTAL (.run(osc_enable), .fail(xtal_fail), .osc_out(osc_in));
   rtc_core #(.OSC_LOSS_CYCLES(LOSS)) DUT (.sys_clk(sys_clk), .nrst(nrst),
      .osc_in(osc_in), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .bus_stop(bus_stop),
      .reg_rdata(reg_rdata), .osc_enable(osc_enable),
      .freq_test_pin_out(ft_out), .freq_test_pin_oe(ft_oe),
      .shared_irq_level_pin_out(sh_out), .shared_irq_level_pin_oe(sh_oe),
      .osc_fail_irq_pin(irq));
   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic stop_cond;
      @(posedge sys_clk);
      bus_stop <= 1'b1;
      @(posedge sys_clk);
      bus_stop <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic ft_half(output int cnt);
      logic last;
      last = ft_oe;
      cnt = 0;
      while (ft_oe === last && cnt < 300) begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end
   endtask
   task automatic wrap_up;
      if (err_total == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(3'(i), RST_VAL[i]);
      end
      chk({7'h00, sh_oe}, 8'h00);
      wr(3'h7, 8'h00);
      chk({7'h00, sh_oe}, 8'h01);
      wr(3'h3, 8'hff);
      rd(3'h3, 8'h07);
      wr(3'h7, 8'ha5);
      rd(3'h7, 8'ha5);
      wr(3'h7, 8'h80);
      wr(3'h0, 8'h80);
      chk({7'h00, osc_enable}, 8'h00);
      wr(3'h0, 8'h00);
      chk({7'h00, osc_enable}, 8'h01);
      wr(3'h1, 8'h80);
      chk({7'h00, irq}, 8'h00);
      wr(3'h0, 8'h80);
      chk({7'h00, irq}, 8'h01);
      chk({7'h00, sh_oe}, 8'h01);
      wr(3'h1, 8'h00);
      chk({7'h00, irq}, 8'h00);
      wr(3'h1, 8'h80);
      wr(3'h0, 8'h00);
      #200;
      chk({7'h00, irq}, 8'h00);
      xtal_fail = 1'b1;
      #(20 * (LOSS + 20));
      chk({7'h00, irq}, 8'h01);
      xtal_fail = 1'b0;
      #400;
      chk({7'h00, irq}, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h7, 8'hc0);
      ft_half(n);
      ft_half(n);
      chk(8'(n), 8'h40);
      wr(3'h7, 8'hff);
      ft_half(n);
      ft_half(n);
      chk(8'(n), 8'h40);
      wr(3'h0, 8'h80);
      ft_half(n);
      chk((n == 300) ? 8'h01 : 8'h00, 8'h01);
      wr(3'h0, 8'h00);
      wr(3'h7, 8'h80);
      for (int i = 6; i >= 0; i--) begin
         wr(3'(i), SET_VAL[i]);
      end
      #(20 * 60000);
      rd(3'h0, 8'h59);
      #(20 * 8000);
      rd(3'h0, 8'h59);
      stop_cond();
      for (int i = 0; i < 7; i++) begin
         rd(3'(i), ROLL_VAL[i]);
      end
      wrap_up();
   end
   initial begin
      #(20 * 90000);
      err_total++;
      wrap_up();
   end
endmodule

bind rtc_core rtc_core_chk #(.LOSS(OSC_LOSS_CYCLES)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .osc_in(osc_in), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .bus_stop(bus_stop), .reg_rdata(reg_rdata), .osc_enable(osc_enable),
   .freq_test_pin_out(freq_test_pin_out),
   .freq_test_pin_oe(freq_test_pin_oe),
   .shared_irq_level_pin_out(shared_irq_level_pin_out),
   .shared_irq_level_pin_oe(shared_irq_level_pin_oe),
   .osc_fail_irq_pin(osc_fail_irq_pin));
